// [dv/tpr_grabber.sv]
// frame grabber model: counts, sums and keeps the last qualified pixel of each frame
`timescale 1ns/1ps
module tpr_grabber (
   input  wire logic        clock,
   input  wire logic        fval,
   input  wire logic        dval,
   input  wire logic [11:0] pix,
   output logic      [15:0] count,
   output logic      [19:0] sum,
   output logic      [11:0] last
);
   logic fval_q = 1'b0;
   // counters restart at each frame start seen on the stream
   always @(posedge clock) begin
      fval_q <= fval;
      if (fval && !fval_q) begin
         count <= 16'h0000;
         sum   <= 20'h00000;
      end else if (dval) begin
         count <= count + 16'h0001;
         sum   <= sum + 20'(pix);
         last  <= pix;
      end
   end
endmodule : tpr_grabber

// [dv/tpr_top_tb.sv]
// self-checking bench of the pattern and windowing block
`timescale 1ns/1ps
module tpr_top_tb;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        in_frame_valid = 1'b0;
   logic        in_line_valid = 1'b0;
   logic [11:0] in_pixel = 12'h000;
   logic        out_frame_valid, out_line_valid, out_data_valid;
   logic [11:0] out_pixel, readout_lines, last;
   logic [15:0] count;
   logic [19:0] sum;
   int          fails = 0;
   int          num_checks = 0;
   int          lcnt = 0;

   tpr_top tpr_top_i (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .in_frame_valid, .in_line_valid, .in_pixel, .out_frame_valid, .out_line_valid,
      .out_data_valid, .out_pixel, .readout_lines);
   tpr_grabber tpr_grabber_i (.clock, .fval(out_frame_valid), .dval(out_data_valid),
      .pix(out_pixel), .count, .sum, .last);

   initial forever #5 clock = ~clock;

   // cycles with line valid high on the output stream
   always @(posedge clock) begin
      if (out_line_valid) lcnt <= lcnt + 1;
   end

   // ----------------------------------------------------------------
   // bus, stream and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rdc

   // four lines of eight pixels, pixel value is column plus one
   task automatic frame();
      @(posedge clock) in_frame_valid <= 1'b1;
      for (int y = 0; y < 4; y++) begin
         for (int x = 0; x < 9; x++) begin
            @(posedge clock);
            in_line_valid <= (x < 8);
            in_pixel      <= (x < 8) ? 12'(x + 1) : 12'h000;
         end
      end
      repeat (3) @(posedge clock);
      in_frame_valid <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : frame

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      rdc(tpr_pkg::REG_CTRL, 32'h00000000);
      rdc(tpr_pkg::REG_LEVEL, 32'h00000fff);
      rdc(tpr_pkg::REG_MWH, 32'h08000800);
      rdc(8'h48, 32'h00000000);
      wr(tpr_pkg::REG_LEVEL, 32'hffff0123);
      rdc(tpr_pkg::REG_LEVEL, 32'h00000123);
      chk(32'(readout_lines), 32'h00000800);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_flat();
      logic [3:0]  m [4] = '{tpr_pkg::TM_OFF, tpr_pkg::TM_BLACK, tpr_pkg::TM_GRAY, tpr_pkg::TM_WHITE};
      logic [11:0] e [4] = '{12'h008, 12'h000, 12'h200, 12'hfff};
      for (int i = 0; i < 4; i++) begin
         wr(tpr_pkg::REG_CTRL, 32'(m[i]));
         frame();
         chk(32'(count), 32'h00000020);
         chk(32'(last), 32'(e[i]));
      end
      $display("t_flat done");
   endtask : t_flat

   task automatic t_next();
      fork
         frame();
         begin
            repeat (12) @(posedge clock);
            wr(tpr_pkg::REG_CTRL, 32'h00000001);
         end
      join
      chk(32'(last), 32'h00000fff);
      frame();
      chk(32'(last), 32'h00000000);
      $display("t_next done");
   endtask : t_next

   task automatic t_master();
      int l0;
      wr(tpr_pkg::REG_MXY, 32'h00010002);
      wr(tpr_pkg::REG_MWH, 32'h00020003);
      wr(tpr_pkg::REG_CTRL, 32'h00001000);
      l0 = lcnt;
      frame();
      chk(32'(count), 32'h00000006);
      chk(lcnt - l0, 32'h00000018);
      chk(32'(sum), 32'h00000018);
      chk(32'(readout_lines), 32'h00000003);
      wr(tpr_pkg::REG_SXY0, 32'h00010003);
      wr(8'h18, 32'h80010001);
      wr(tpr_pkg::REG_CTRL, 32'h00003000);
      frame();
      chk(32'(count), 32'h00000005);
      chk(32'(sum), 32'h00000014);
      chk(32'(readout_lines), 32'h00000800);
      wr(8'h18, 32'h00000000);
      $display("t_master done");
   endtask : t_master

   task automatic t_bin();
      logic [31:0] c [4] = '{32'h00000040, 32'h00000200, 32'h00000680, 32'h00000900};
      logic [31:0] n [4] = '{32'h00000010, 32'h00000010, 32'h00000002, 32'h00000001};
      logic [31:0] s [4] = '{32'h00000090, 32'h00000048, 32'h00000015, 32'h00000024};
      logic [31:0] l [4] = '{32'h00000020, 32'h00000010, 32'h00000008, 32'h00000008};
      int          l0;
      for (int i = 0; i < 4; i++) begin
         wr(tpr_pkg::REG_CTRL, c[i]);
         l0 = lcnt;
         frame();
         chk(32'(count), n[i]);
         chk(32'(sum), s[i]);
         chk(lcnt - l0, l[i]);
      end
      $display("t_bin done");
   endtask : t_bin

   // moving ramps run in frames 13 and 14, so the phase equals the frame number
   task automatic t_pattern();
      logic [31:0] c [7] = '{32'h006, 32'h007, 32'h004, 32'h005, 32'h008, 32'h020, 32'h060};
      logic [31:0] s [7] = '{32'h210, 32'h1f0, 32'h070, 32'h030, 32'h3fe0, 32'hce4, 32'h090};
      logic [11:0] e [7] = '{12'h014, 12'h011, 12'h007, 12'h003, 12'h1ff, 12'h008, 12'h00f};
      rdc(tpr_pkg::REG_STATUS, 32'h0000000c);
      wr(tpr_pkg::REG_LINES, 32'h00030002);
      for (int i = 0; i < 7; i++) begin
         wr(tpr_pkg::REG_CTRL, c[i]);
         frame();
         chk(32'(sum), s[i]);
         chk(32'(last), 32'(e[i]));
      end
      $display("t_pattern done");
   endtask : t_pattern

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   initial begin
      #100us;
      fails++;
      print_verdict();
   end

   initial begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      t_regs();
      t_flat();
      t_next();
      t_master();
      t_bin();
      t_pattern();
      print_verdict();
   end
endmodule : tpr_top_tb

// [hw/tpr_pkg.sv]
// constants, register map and helper functions of the test pattern and region windowing block
package tpr_pkg;

   // ----------------------------------------------------------------
   // widths and sensor geometry
   // ----------------------------------------------------------------
   localparam int          CW         = 12;
   localparam int          PW         = 12;
   localparam int          AW         = 8;
   localparam int          DW         = 32;
   localparam logic [11:0] SENSOR_W   = 12'h800;
   localparam logic [11:0] SENSOR_H   = 12'h800;
   localparam logic [11:0] CROSS_X    = 12'h400;
   localparam logic [11:0] CROSS_Y    = 12'h400;
   localparam int          BAR_SHIFT  = 8;

   // ----------------------------------------------------------------
   // register map (byte addresses, index = address / 4)
   // ----------------------------------------------------------------
   localparam int          NCFG       = 17;
   localparam int          NREGION    = 7;
   localparam int          IDX_CTRL   = 0;
   localparam int          IDX_LEVEL  = 1;
   localparam int          IDX_LINES  = 2;
   localparam int          IDX_REG0   = 3;
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_LEVEL  = 8'h04;
   localparam logic [7:0]  REG_LINES  = 8'h08;
   localparam logic [7:0]  REG_MXY    = 8'h0c;
   localparam logic [7:0]  REG_MWH    = 8'h10;
   localparam logic [7:0]  REG_SXY0   = 8'h14;
   localparam logic [7:0]  REG_STATUS = 8'h44;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          TEST_LSB   = 0;
   localparam int          OVL_LSB    = 4;
   localparam int          HBIN_LSB   = 6;
   localparam int          VBIN_LSB   = 9;
   localparam int          MEN_BIT    = 12;
   localparam int          KEEP_BIT   = 13;
   localparam int          Y_LSB      = 16;
   localparam int          SMODE_LSB  = 30;
   localparam int          INFR_BIT   = 16;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST   = 32'h00000000;
   localparam logic [31:0] LEVEL_RST  = 32'h00000fff;
   localparam logic [31:0] MWH_RST    = 32'h08000800;
   localparam logic [31:0] ZERO_RST   = 32'h00000000;
   localparam logic [31:0] CTRL_MASK  = 32'h00003fff;
   localparam logic [31:0] LEVEL_MASK = 32'h00000fff;
   localparam logic [31:0] XY_MASK    = 32'h0fff0fff;
   localparam logic [31:0] SWH_MASK   = 32'hcfff0fff;

   // ----------------------------------------------------------------
   // modes and levels
   // ----------------------------------------------------------------
   localparam logic [3:0]  TM_OFF     = 4'h0;
   localparam logic [3:0]  TM_BLACK   = 4'h1;
   localparam logic [3:0]  TM_GRAY    = 4'h2;
   localparam logic [3:0]  TM_WHITE   = 4'h3;
   localparam logic [3:0]  TM_HRAMP   = 4'h4;
   localparam logic [3:0]  TM_VRAMP   = 4'h5;
   localparam logic [3:0]  TM_HMOVE   = 4'h6;
   localparam logic [3:0]  TM_VMOVE   = 4'h7;
   localparam logic [3:0]  TM_BARS    = 4'h8;
   localparam logic [1:0]  OV_NONE    = 2'h0;
   localparam logic [1:0]  OV_CROSS   = 2'h1;
   localparam logic [1:0]  OV_LINES   = 2'h2;
   localparam logic [1:0]  SM_INC     = 2'h1;
   localparam logic [1:0]  SM_EXC     = 2'h2;
   localparam logic [11:0] LVL_BLACK  = 12'h000;
   localparam logic [11:0] LVL_GRAY   = 12'h200;
   localparam logic [11:0] LVL_WHITE  = 12'hfff;
   localparam logic [11:0] LVL_MAX    = 12'hfff;
   localparam logic [8:0]  BAR_LOW    = 9'h1ff;
   localparam logic [11:0] PHASE_STEP = 12'h001;

   // binning code to factor: 0..4 give 1x, 2x, 3x, 4x, 8x
   function automatic logic [3:0] tpr_bin_factor(input logic [2:0] code);
      case (code)
         3'h1:    tpr_bin_factor = 4'h2;
         3'h2:    tpr_bin_factor = 4'h3;
         3'h3:    tpr_bin_factor = 4'h4;
         3'h4:    tpr_bin_factor = 4'h8;
         default: tpr_bin_factor = 4'h1;
      endcase
   endfunction : tpr_bin_factor

   function automatic logic [31:0] tpr_reset_value(input int idx);
      case (idx)
         IDX_CTRL:  tpr_reset_value = CTRL_RST;
         IDX_LEVEL: tpr_reset_value = LEVEL_RST;
         4:         tpr_reset_value = MWH_RST;
         default:   tpr_reset_value = ZERO_RST;
      endcase
   endfunction : tpr_reset_value

   function automatic logic [31:0] tpr_write_mask(input int idx);
      if (idx == IDX_CTRL) begin
         tpr_write_mask = CTRL_MASK;
      end else if (idx == IDX_LEVEL) begin
         tpr_write_mask = LEVEL_MASK;
      end else if (idx > 4 && idx[0] == 1'b0) begin
         tpr_write_mask = SWH_MASK;
      end else begin
         tpr_write_mask = XY_MASK;
      end
   endfunction : tpr_write_mask

endpackage : tpr_pkg

// [hw/tpr_region.sv]
// one rectangular window hit test, origin at the top-left pixel
`timescale 1ns/1ps
module tpr_region (
   input  wire logic [11:0] pos_x,
   input  wire logic [11:0] pos_y,
   input  wire logic [11:0] off_x,
   input  wire logic [11:0] off_y,
   input  wire logic [11:0] width,
   input  wire logic [11:0] height,
   output logic             hit
);
   logic [12:0] end_x;
   logic [12:0] end_y;

   assign end_x = {1'b0, off_x} + {1'b0, width};
   assign end_y = {1'b0, off_y} + {1'b0, height};
   assign hit   = (pos_x >= off_x) && ({1'b0, pos_x} < end_x) &&
                  (pos_y >= off_y) && ({1'b0, pos_y} < end_y);
endmodule : tpr_region

// [hw/tpr_top.sv]
// test pattern, overlay, binning and region windowing on the camera pixel path
//
// Summary of operation
// R01 - test selector: off plus eight synthetic patterns replacing the live image
// R02 - flat frames: black, dark gray, white, each selectable
// R03 - stationary ramps rising along x or along y
// R04 - moving horizontal and vertical ramps shift each frame
// R05 - eight vertical gray bars of distinct levels across the line
// R06 - overlay on live image, disabled whenever any binning is active
// R07 - crosshair centered on the sensor image
// R08 - horizontal and/or vertical line at programmable 1-based positions
// R09 - overlay pixel level programmable 0 to 4095
// R10 - horizontal binning by 1x, 2x, 3x, 4x or 8x
// R11 - vertical binning by 1x, 2x, 3x, 4x or 8x
// R12 - normal window passes full resolution framed by line and frame valid
// R13 - seven regions: one master, six slaves, each with offset and size
// R14 - enabled master region sets image size; data valid only inside it
// R15 - keep-frame-rate holds the frame period regardless of master size
// R16 - without keep-frame-rate the frame period follows master y offset plus height
// R17 - software enables master first and keeps slaves inside it
// R18 - each enabled slave either includes or excludes its pixels
// R19 - coordinates count from the top-left pixel
// R20 - moving ramps advance one level per frame start, wrapping
// R21 - configuration takes effect only at the next frame start
`timescale 1ns/1ps
module tpr_top (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        in_frame_valid,
   input  wire logic        in_line_valid,
   input  wire logic [11:0] in_pixel,
   output logic             out_frame_valid,
   output logic             out_line_valid,
   output logic             out_data_valid,
   output logic      [11:0] out_pixel,
   output logic      [11:0] readout_lines
);

   // ----------------------------------------------------------------
   // register file: shadow copies written by software
   // ----------------------------------------------------------------
   logic [31:0] cfg       [tpr_pkg::NCFG];
   logic [31:0] next_cfg  [tpr_pkg::NCFG];
   logic [31:0] next_rdata;
   logic [31:0] act       [tpr_pkg::NCFG];
   logic [31:0] next_act  [tpr_pkg::NCFG];
   logic [11:0] phase;
   logic [11:0] next_phase;
   logic [15:0] frame_cnt;
   logic [15:0] next_frame_cnt;
   logic        fval_d;
   logic        lval_d;
   logic [11:0] x;
   logic [11:0] y;
   logic [3:0]  hcnt;
   logic [15:0] acc;
   logic [3:0]  vcnt;
   logic        next_fval_d;
   logic        next_lval_d;
   logic [11:0] next_x;
   logic [11:0] next_y;
   logic [3:0]  next_hcnt;
   logic [15:0] next_acc;
   logic [3:0]  next_vcnt;
   logic        next_out_fval;
   logic        next_out_lval;
   logic        next_out_dval;
   logic [11:0] next_out_pixel;
   logic [11:0] next_readout;
   logic        frame_start;
   logic        line_end;
   logic [5:0]  widx;

   assign frame_start = in_frame_valid && !fval_d;
   assign line_end    = lval_d && !in_line_valid;
   assign widx        = reg_addr[7:2];

   always_comb begin
      for (int i = 0; i < tpr_pkg::NCFG; i++) begin
         next_cfg[i] = cfg[i];
         if (reg_wr && reg_addr[1:0] == 2'h0 && widx == 6'(i)) begin
            next_cfg[i] = reg_wdata & tpr_pkg::tpr_write_mask(i);
         end
      end
      next_rdata = 32'h00000000;
      if (reg_rd) begin
         if (reg_addr == tpr_pkg::REG_STATUS) begin
            next_rdata = {15'h0000, fval_d, frame_cnt};
         end else if (reg_addr[1:0] == 2'h0 && widx < 6'(tpr_pkg::NCFG)) begin
            next_rdata = cfg[widx[4:0]];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < tpr_pkg::NCFG; i++) begin
            cfg[i] <= tpr_pkg::tpr_reset_value(i);
         end
         reg_rdata <= 32'h00000000;
      end else begin
         cfg       <= next_cfg;
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // active configuration, loaded at frame start
   // ----------------------------------------------------------------
   always_comb begin
      next_act       = act;
      next_phase     = phase;
      next_frame_cnt = frame_cnt;
      if (frame_start) begin
         next_act       = cfg;                                 // R21
         next_phase     = phase + tpr_pkg::PHASE_STEP;         // R20
         next_frame_cnt = frame_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < tpr_pkg::NCFG; i++) begin
            act[i] <= tpr_pkg::tpr_reset_value(i);
         end
         phase     <= 12'h000;
         frame_cnt <= 16'h0000;
      end else begin
         act       <= next_act;
         phase     <= next_phase;
         frame_cnt <= next_frame_cnt;
      end
   end

   // ----------------------------------------------------------------
   // decoded active fields
   // ----------------------------------------------------------------
   logic [3:0]  test;
   logic [1:0]  ovl;
   logic [3:0]  hf;
   logic [3:0]  vf;
   logic        men;
   logic        keep;
   logic [11:0] level;
   logic [11:0] hline_y;
   logic [11:0] vline_x;
   logic [6:0]  hit;

   assign test    = act[tpr_pkg::IDX_CTRL][tpr_pkg::TEST_LSB +: 4];
   assign ovl     = act[tpr_pkg::IDX_CTRL][tpr_pkg::OVL_LSB +: 2];
   assign hf      = tpr_pkg::tpr_bin_factor(act[tpr_pkg::IDX_CTRL][tpr_pkg::HBIN_LSB +: 3]);
   assign vf      = tpr_pkg::tpr_bin_factor(act[tpr_pkg::IDX_CTRL][tpr_pkg::VBIN_LSB +: 3]);
   assign men     = act[tpr_pkg::IDX_CTRL][tpr_pkg::MEN_BIT];
   assign keep    = act[tpr_pkg::IDX_CTRL][tpr_pkg::KEEP_BIT];
   assign level   = act[tpr_pkg::IDX_LEVEL][11:0];                                  // R09
   assign hline_y = act[tpr_pkg::IDX_LINES][11:0];
   assign vline_x = act[tpr_pkg::IDX_LINES][tpr_pkg::Y_LSB +: 12];

   // ----------------------------------------------------------------
   // region hit tests: region 0 is the master, 1..6 the slaves
   // ----------------------------------------------------------------
   for (genvar r = 0; r < tpr_pkg::NREGION; r++) begin : g_region
      tpr_region u_region (                                                         // R13 R19
         .pos_x  (x),
         .pos_y  (y),
         .off_x  (act[tpr_pkg::IDX_REG0 + 2 * r][11:0]),
         .off_y  (act[tpr_pkg::IDX_REG0 + 2 * r][tpr_pkg::Y_LSB +: 12]),
         .width  (act[tpr_pkg::IDX_REG0 + 2 * r + 1][11:0]),
         .height (act[tpr_pkg::IDX_REG0 + 2 * r + 1][tpr_pkg::Y_LSB +: 12]),
         .hit    (hit[r])
      );
   end

   logic        inc_any;
   logic        inc_hit;
   logic        exc_hit;
   logic        roi_ok;
   logic [12:0] m_end_y;
   logic        rows_ok;
   logic [1:0]  smode;

   always_comb begin
      inc_any = 1'b0;
      inc_hit = 1'b0;
      exc_hit = 1'b0;
      smode   = 2'h0;
      for (int s = 1; s < tpr_pkg::NREGION; s++) begin
         smode = act[tpr_pkg::IDX_REG0 + 2 * s + 1][tpr_pkg::SMODE_LSB +: 2];
         if (smode == tpr_pkg::SM_INC) begin                                        // R18
            inc_any = 1'b1;
            inc_hit = inc_hit || hit[s];
         end else if (smode == tpr_pkg::SM_EXC) begin
            exc_hit = exc_hit || hit[s];
         end
      end
   end

   // slaves count only under an enabled master and are assumed to lie inside it
   assign roi_ok  = !men || (hit[0] && !exc_hit && (!inc_any || inc_hit));         // R14 R17 R18
   assign m_end_y = {1'b0, act[tpr_pkg::IDX_REG0][tpr_pkg::Y_LSB +: 12]} +
                    {1'b0, act[tpr_pkg::IDX_REG0 + 1][tpr_pkg::Y_LSB +: 12]};
   assign rows_ok = keep || !men || ({1'b0, y} < m_end_y);                         // R15 R16

   // ----------------------------------------------------------------
   // pattern generation and overlay
   // ----------------------------------------------------------------
   logic [11:0] pat;
   logic [11:0] src;
   logic        ovl_on;
   logic        ovl_hit;
   logic [11:0] px;
   logic [2:0]  bar;

   assign bar = 3'(x >> tpr_pkg::BAR_SHIFT);

   always_comb begin
      case (test)                                                                   // R01
         tpr_pkg::TM_BLACK: pat = tpr_pkg::LVL_BLACK;                               // R02
         tpr_pkg::TM_GRAY:  pat = tpr_pkg::LVL_GRAY;                                // R02
         tpr_pkg::TM_WHITE: pat = tpr_pkg::LVL_WHITE;                               // R02
         tpr_pkg::TM_HRAMP: pat = x;                                                // R03
         tpr_pkg::TM_VRAMP: pat = y;                                                // R03
         tpr_pkg::TM_HMOVE: pat = x + phase;                                        // R04
         tpr_pkg::TM_VMOVE: pat = y + phase;                                        // R04
         tpr_pkg::TM_BARS:  pat = {bar, tpr_pkg::BAR_LOW};                          // R05
         default:           pat = in_pixel;
      endcase
      src     = (test == tpr_pkg::TM_OFF) ? in_pixel : pat;                         // R12
      ovl_on  = (ovl != tpr_pkg::OV_NONE) && (test == tpr_pkg::TM_OFF) &&
                (hf == 4'h1) && (vf == 4'h1);                                       // R06
      case (ovl)
         tpr_pkg::OV_CROSS: ovl_hit = (x == tpr_pkg::CROSS_X) || (y == tpr_pkg::CROSS_Y);  // R07
         tpr_pkg::OV_LINES: ovl_hit = (hline_y != 12'h000 && y == hline_y - 12'h001) ||
                                      (vline_x != 12'h000 && x == vline_x - 12'h001);      // R08
         default:           ovl_hit = 1'b0;
      endcase
      px = (ovl_on && ovl_hit) ? level : src;                                       // R09
   end

   // ----------------------------------------------------------------
   // position counters and binning
   // ----------------------------------------------------------------
   logic [15:0] sum;
   logic        hlast;
   logic        line_kept;
   logic [11:0] binned;
   logic        emit;

   assign sum       = ((hcnt == 4'h0) ? 16'h0000 : acc) + {4'h0, px};
   assign hlast     = (hcnt == hf - 4'h1);
   assign line_kept = (vcnt == 4'h0);                                               // R11
   assign binned    = (sum > {4'h0, tpr_pkg::LVL_MAX}) ? tpr_pkg::LVL_MAX : sum[11:0];
   assign emit      = in_line_valid && line_kept && hlast && rows_ok;              // R10

   always_comb begin
      next_fval_d = in_frame_valid;
      next_lval_d = in_line_valid;
      next_x      = in_line_valid ? x + 12'h001 : 12'h000;                          // R19
      next_y      = y;
      next_hcnt   = 4'h0;
      next_acc    = sum;
      next_vcnt   = vcnt;
      if (in_line_valid && !hlast) begin
         next_hcnt = hcnt + 4'h1;                                                   // R10
      end
      if (frame_start) begin
         next_y    = 12'h000;
         next_vcnt = 4'h0;
      end else if (line_end) begin
         next_y    = y + 12'h001;
         next_vcnt = (vcnt == vf - 4'h1) ? 4'h0 : vcnt + 4'h1;                      // R11
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fval_d <= 1'b0;
         lval_d <= 1'b0;
         x      <= 12'h000;
         y      <= 12'h000;
         hcnt   <= 4'h0;
         acc    <= 16'h0000;
         vcnt   <= 4'h0;
      end else begin
         fval_d <= next_fval_d;
         lval_d <= next_lval_d;
         x      <= next_x;
         y      <= next_y;
         hcnt   <= next_hcnt;
         acc    <= next_acc;
         vcnt   <= next_vcnt;
      end
   end

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   always_comb begin
      next_out_fval  = in_frame_valid && rows_ok;                                   // R16
      next_out_lval  = in_line_valid && line_kept && rows_ok;                       // R12
      next_out_dval  = emit && roi_ok;                                              // R14
      next_out_pixel = emit ? binned : 12'h000;
      next_readout   = tpr_pkg::SENSOR_H;                                           // R15
      if (men && !keep) begin
         next_readout = (m_end_y > {1'b0, tpr_pkg::SENSOR_H}) ? tpr_pkg::SENSOR_H : m_end_y[11:0];  // R16
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         out_frame_valid <= 1'b0;
         out_line_valid  <= 1'b0;
         out_data_valid  <= 1'b0;
         out_pixel       <= 12'h000;
         readout_lines   <= tpr_pkg::SENSOR_H;
      end else begin
         out_frame_valid <= next_out_fval;
         out_line_valid  <= next_out_lval;
         out_data_valid  <= next_out_dval;
         out_pixel       <= next_out_pixel;
         readout_lines   <= next_readout;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   AST_BLACK: assert property ((test == tpr_pkg::TM_BLACK && emit && hf == 4'h1) |=> // R02
         out_pixel == tpr_pkg::LVL_BLACK) else $error("black frame pixel not zero");
   AST_WHITE: assert property ((test == tpr_pkg::TM_WHITE && emit && hf == 4'h1) |=> // R02
         out_pixel == tpr_pkg::LVL_WHITE) else $error("white frame pixel not full scale");
   AST_HRAMP: assert property ((test == tpr_pkg::TM_HRAMP && emit && hf == 4'h1) |=> // R03
         out_pixel == $past(x)) else $error("horizontal ramp does not follow column");
   AST_PHASE: assert property (frame_start |=> phase == $past(phase) + tpr_pkg::PHASE_STEP) // R20
         else $error("moving ramp phase did not advance");
   AST_HOLD: assert property (!frame_start |=> $stable(act[tpr_pkg::IDX_CTRL]))     // R21
         else $error("active configuration changed inside a frame");
   AST_NO_OVL: assert property ((hf != 4'h1 || vf != 4'h1) |-> !ovl_on)            // R06
         else $error("overlay active while binning");
   AST_DVAL_ROI: assert property (out_data_valid |-> $past(!men || hit[0]))        // R14
         else $error("data valid outside master region");
   AST_EXCL: assert property (($past(men) && out_data_valid) |-> !$past(exc_hit))  // R18
         else $error("excluded pixel marked valid");
   AST_KEEP: assert property ((keep || !men) |=> readout_lines == tpr_pkg::SENSOR_H) // R15
         else $error("frame period changed under keep-frame-rate");
   AST_VBIN: assert property (!line_kept |=> !out_line_valid)                      // R11
         else $error("binned-away line emitted");

endmodule : tpr_top
